// *** design/sao_port.sv ***
// Summary of operation
// - Config bit 2 puts shared pins in audio mode; clear means GPIO.
// - After reset the port is disabled and pins act as GPIO.
// - Config bit 3 gates the master clock output pin toward the DAC.
// - Master clock is input clock, or half of it in high clock range.
// - Rate field bits 1:0: 10=192 kHz, 01=96 kHz, 00=48 kHz.
// - Bit clock is master clock divided by 8, 4 or 2 per rate.

module sao_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input  wire logic             ref_clk_i,
    input  wire logic             nrst_i,
    input  wire logic             ce_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             push;
    logic             pop;

    assign push        = ce_i && in_valid_i && in_ready_o;
    assign pop         = ce_i && out_valid_o && out_ready_i;
    assign in_ready_o  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid_o = wr_ptr != rd_ptr;
    assign out_data_o  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

module sao_port (
    input  wire logic                         ref_clk_i,
    input  wire logic                         nrst_i,
    input  wire logic                         ce_i,
    // register port of the processor core
    input  wire logic [15:0]                  reg_addr_i,
    input  wire logic                         reg_wr_i,
    input  wire logic [15:0]                  reg_wdata_i,
    output logic      [15:0]                  reg_rdata_o,
    input  wire logic                         high_input_clock_range_i,
    // decoded stereo samples
    input  wire logic                         smp_valid_i,
    output logic                              smp_ready_o,
    input  wire logic [2*sao_pkg::SAMPLE_W-1:0] smp_data_i,
    // general-purpose I/O owned by the core while the port is off
    input  wire logic [sao_pkg::GPIO_W-1:0]   gpio_out_i,
    input  wire logic [sao_pkg::GPIO_W-1:0]   gpio_oe_i,
    // shared pins: 0 mclk, 1 sclk, 2 word select, 3 data
    output logic      [sao_pkg::GPIO_W-1:0]   pin_o,
    output logic      [sao_pkg::GPIO_W-1:0]   pin_oe_o
);
    localparam int SW = sao_pkg::SAMPLE_W;

    logic [sao_pkg::CFG_W-1:0] serial_audio_out_config;
    logic                      audio_port_enable;
    logic                      master_clock_out_enable;
    logic [1:0]                output_rate_select;
    logic                      mclk_tick;
    logic                      mclk_ph;
    logic [3:0]                div_cnt;
    logic                      sclk;
    logic                      ws;
    logic [4:0]                bit_cnt;
    logic [SW-1:0]             shreg;
    logic [SW-1:0]             right_hold;
    logic                      fifo_valid;
    logic                      fifo_pop;
    logic [2*SW-1:0]           fifo_data;
    logic                      sclk_fall;
    logic [3:0]                half_div;

    function automatic logic [3:0] rate_div(input logic [1:0] code);
        unique case (code)
            sao_pkg::RATE_96:  rate_div = sao_pkg::DIV_96;
            sao_pkg::RATE_192: rate_div = sao_pkg::DIV_192;
            default:           rate_div = sao_pkg::DIV_48;
        endcase
    endfunction

    assign audio_port_enable       = serial_audio_out_config[sao_pkg::BIT_PORT_EN];
    assign master_clock_out_enable = serial_audio_out_config[sao_pkg::BIT_MCLK_EN];
    assign output_rate_select      = serial_audio_out_config[sao_pkg::RATE_HI:sao_pkg::RATE_LO];

    // ----------------------------------------
    // configuration register
    // ----------------------------------------
    // reset leaves port off
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            serial_audio_out_config <= sao_pkg::CFG_RESET;
        end else if (ce_i && reg_wr_i && reg_addr_i == sao_pkg::CFG_ADDR) begin
            serial_audio_out_config <= reg_wdata_i[sao_pkg::CFG_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= '0;
        end else if (ce_i) begin
            reg_rdata_o <= (reg_addr_i == sao_pkg::CFG_ADDR) ?
                           {12'h000, serial_audio_out_config} : 16'h0000;
        end
    end

    // ----------------------------------------
    // master clock
    // ----------------------------------------
    // halve in high range; mclk_tick marks one master-clock period
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mclk_ph <= 1'b0;
        end else if (ce_i) begin
            mclk_ph <= high_input_clock_range_i ? ~mclk_ph : 1'b0;
        end
    end
    assign mclk_tick = !high_input_clock_range_i || mclk_ph;

    // ----------------------------------------
    // bit clock and frame
    // ----------------------------------------
    // rate selects divider; sclk toggles every half period
    assign half_div  = rate_div(output_rate_select) >> 1;
    // compare with >= so a rate change to a shorter divider never waits for a wrap
    assign sclk_fall = mclk_tick && div_cnt >= half_div - 4'h1 && sclk;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_cnt <= '0;
            sclk    <= 1'b0;
        end else if (ce_i) begin
            if (!audio_port_enable) begin
                div_cnt <= '0;
                sclk    <= 1'b0;
            end else if (mclk_tick) begin
                if (div_cnt >= half_div - 4'h1) begin
                    div_cnt <= '0;
                    sclk    <= ~sclk;
                end else begin
                    div_cnt <= div_cnt + 4'h1;
                end
            end
        end
    end

    // ws toggles per channel, data msb first, one bit late
    assign fifo_pop = sclk_fall && bit_cnt == 5'(SW - 1) && !ws;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bit_cnt    <= '0;
            ws         <= 1'b0;
            shreg      <= '0;
            right_hold <= '0;
        end else if (ce_i) begin
            if (!audio_port_enable) begin
                bit_cnt    <= '0;
                ws         <= 1'b0;
                shreg      <= '0;
                right_hold <= '0;
            end else if (sclk_fall) begin
                if (bit_cnt == 5'(SW - 1)) begin
                    bit_cnt <= '0;
                end else begin
                    bit_cnt <= bit_cnt + 5'h1;
                end
                // ws leads the word by one bit: old lsb goes out under the new select
                if (bit_cnt == 5'(SW - 2)) begin
                    ws <= ~ws;
                end
                if (bit_cnt == 5'(SW - 1) && !ws) begin
                    shreg      <= fifo_valid ? fifo_data[2*SW-1:SW] : '0;
                    // underrun sends silence rather than stale data
                    right_hold <= fifo_valid ? fifo_data[SW-1:0] : '0;
                end else if (bit_cnt == 5'(SW - 1)) begin
                    shreg <= right_hold;
                end else begin
                    shreg <= {shreg[SW-2:0], 1'b0};
                end
            end
        end
    end

    sao_fifo #(
        .WIDTH (2*SW),
        .DEPTH (sao_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i   (ref_clk_i),
        .nrst_i      (nrst_i),
        .ce_i        (ce_i),
        .in_valid_i  (smp_valid_i),
        .in_ready_o  (smp_ready_o),
        .in_data_i   (smp_data_i),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop),
        .out_data_o  (fifo_data)
    );

    // ----------------------------------------
    // pin mux
    // ----------------------------------------
    // audio mode owns pins; mclk gated by bit 3
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_o    <= '0;
            pin_oe_o <= '0;
        end else if (ce_i) begin
            if (audio_port_enable) begin
                pin_o    <= {shreg[SW-1], ws, sclk,
                             master_clock_out_enable & (mclk_ph | !high_input_clock_range_i)};
                pin_oe_o <= '1;
            end else begin
                pin_o    <= gpio_out_i;
                pin_oe_o <= gpio_oe_i;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_reset_off: assert property (@(posedge ref_clk_i) $rose(nrst_i) |-> !audio_port_enable)
        else $error("port enabled after reset");
    a_gpio_mode: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        ce_i && !audio_port_enable |=> pin_o == $past(gpio_out_i))
        else $error("gpio not passed through");
    a_audio_oe: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        ce_i && audio_port_enable |=> pin_oe_o == '1)
        else $error("audio pins not driven");
    a_mclk_gate: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        ce_i && !master_clock_out_enable |=> !pin_o[0] || !$past(audio_port_enable))
        else $error("mclk not gated");
    a_mclk_half: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        ce_i && high_input_clock_range_i && $past(ce_i) && $past(high_input_clock_range_i)
        |-> mclk_ph != $past(mclk_ph))
        else $error("mclk not halved");
    a_rate_code: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        $past(ce_i) && $past(audio_port_enable) && !$past(high_input_clock_range_i)
        && $past(output_rate_select) == sao_pkg::RATE_192 |-> sclk != $past(sclk))
        else $error("rate code decode wrong");
    a_sclk_div: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        ce_i && audio_port_enable && !high_input_clock_range_i
        && output_rate_select == sao_pkg::RATE_96 && $rose(sclk) ##1 ce_i [*2]
        |-> sclk == 1'b0)
        else $error("sclk divide wrong");
    a_ws_word: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        ce_i && sclk_fall && bit_cnt != 5'(SW - 2) |=> $stable(ws))
        else $error("ws toggled mid word");
    c_enable: cover property (@(posedge ref_clk_i) $rose(audio_port_enable));
    c_frame: cover property (@(posedge ref_clk_i) fifo_pop && fifo_valid);
    c_full: cover property (@(posedge ref_clk_i) !smp_ready_o);
endmodule

// *** include/sao_pkg.sv ***
package sao_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [15:0] CFG_ADDR      = 16'hc040;
    localparam int          CFG_W         = 4;
    localparam logic [3:0]  CFG_RESET     = 4'h0;
    localparam int          BIT_MCLK_EN   = 3;
    localparam int          BIT_PORT_EN   = 2;
    localparam int          RATE_HI       = 1;
    localparam int          RATE_LO       = 0;

    // ----------------------------------------
    // rate codes
    // ----------------------------------------
    localparam logic [1:0]  RATE_48       = 2'h0;
    localparam logic [1:0]  RATE_96       = 2'h1;
    localparam logic [1:0]  RATE_192      = 2'h2;

    // ----------------------------------------
    // bit-clock dividers, in master-clock periods
    // ----------------------------------------
    localparam logic [3:0]  DIV_48        = 4'h8;
    localparam logic [3:0]  DIV_96        = 4'h4;
    localparam logic [3:0]  DIV_192       = 4'h2;

    // ----------------------------------------
    // stream
    // ----------------------------------------
    localparam int          SAMPLE_W      = 16;
    localparam int          FIFO_DEPTH    = 16;
    localparam int          GPIO_W        = 4;
endpackage

// *** tb/sao_dac_model.sv ***
module sao_dac_model (
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    input  wire logic [3:0]  pin_i,
    output logic             pair_valid_o,
    output logic      [31:0] pair_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        sclk_q;
    logic        ws_q;
    logic [15:0] sh;
    logic [15:0] left_q;
    logic [15:0] word;
    assign word = {sh[14:0], pin_i[3]};
    // msb first, lsb lands on the rise after ws moves
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sclk_q       <= 1'b0;
            ws_q         <= 1'b0;
            pair_valid_o <= 1'b0;
        end else begin
            sclk_q       <= pin_i[1];
            pair_valid_o <= 1'b0;
            if (pin_i[1] && !sclk_q) begin
                sh   <= word;
                ws_q <= pin_i[2];
                if (pin_i[2] != ws_q && !ws_q)
                    left_q <= word;
                if (pin_i[2] != ws_q && ws_q) begin
                    pair_valid_o <= 1'b1;
                    pair_o       <= {left_q, word};
                end
            end
        end
    end
endmodule

// *** tb/serial_audio_dac_output_port_tb.sv ***
module serial_audio_dac_output_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0;
    logic        reg_wr_i = 1'b0;
    logic [15:0] reg_wdata_i = 16'h0;
    logic [15:0] reg_rdata_o;
    logic        hi_rng = 1'b0;
    logic        smp_valid_i = 1'b0;
    logic        smp_ready_o;
    logic [31:0] smp_data_i = 32'h0;
    logic [3:0]  gpio_out_i = 4'h0;
    logic [3:0]  gpio_oe_i = 4'h0;
    logic [3:0]  pin_o;
    logic [3:0]  pin_oe_o;
    logic        pair_valid;
    logic [31:0] pair;
    logic        watch = 1'b0;
    logic [31:0] exp_q[$];
    int          n_errors = 0;
    int          tests_run = 0;

    always #2.5 ref_clk_i = ~ref_clk_i;

    sao_port dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_i(1'b1),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .high_input_clock_range_i(hi_rng),
        .smp_valid_i(smp_valid_i), .smp_ready_o(smp_ready_o), .smp_data_i(smp_data_i),
        .gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o));
    sao_dac_model dac (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .pin_i(pin_o),
        .pair_valid_o(pair_valid), .pair_o(pair));

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic give_up();
        n_errors++;
        end_of_test();
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge ref_clk_i);
        reg_addr_i  = a;
        reg_wdata_i = d;
        reg_wr_i    = 1'b1;
        @(negedge ref_clk_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(negedge ref_clk_i);
        reg_addr_i = a;
        @(negedge ref_clk_i);
        chk_val({16'h0, reg_rdata_o}, {16'h0, e});
    endtask
    function automatic int exp_period(input logic [1:0] c, input logic h);
        logic [3:0] d;
        d = (c == sao_pkg::RATE_192) ? sao_pkg::DIV_192 :
            (c == sao_pkg::RATE_96) ? sao_pkg::DIV_96 : sao_pkg::DIV_48;
        return int'(d) * (h ? 2 : 1);
    endfunction
    // toggles times 16 plus highs over 8 samples
    function automatic int exp_mclk(input logic e, input logic h);
        return !e ? 0 : (h ? 8 * 16 + 4 : 8);
    endfunction
    task automatic measure(output int p, output int m);
        int   first;
        int   h;
        int   t;
        logic prev;
        p = 0;
        first = -1;
        h = 0;
        t = 0;
        prev = pin_o[0];
        for (int n = 0; n < 8; n++) begin
            @(negedge ref_clk_i);
            t += int'(pin_o[0] != prev);
            h += int'(pin_o[0]);
            prev = pin_o[0];
        end
        m = t * 16 + h;
        prev = pin_o[1];
        for (int n = 0; n < 100 && p == 0; n++) begin
            @(negedge ref_clk_i);
            if (pin_o[1] && !prev) begin
                if (first < 0)
                    first = n;
                else
                    p = n - first;
            end
            prev = pin_o[1];
        end
        if (p == 0)
            give_up();
    endtask

    // zero pairs are underrun fill, not data
    always @(negedge ref_clk_i)
        if (watch && pair_valid && pair !== 32'h0) begin
            if (exp_q.size() == 0)
                give_up();
            else
                chk_val(pair, exp_q.pop_front());
        end

    initial begin
        logic [15:0] w;
        int          p;
        int          m;
        void'($urandom(32'hbcd0));
        gpio_out_i = 4'($urandom);
        gpio_oe_i  = 4'($urandom);
        repeat (8) @(negedge ref_clk_i);
        nrst_i = 1'b1;
        repeat (2) @(negedge ref_clk_i);
        chk_val({24'h0, pin_oe_o, pin_o}, {24'h0, gpio_oe_i, gpio_out_i});
        rd(sao_pkg::CFG_ADDR, {12'h0, sao_pkg::CFG_RESET});
        repeat (6) begin
            w = 16'($urandom);
            gpio_out_i = 4'($urandom);
            wr(sao_pkg::CFG_ADDR, w);
            rd(sao_pkg::CFG_ADDR, {12'h0, w[3:0]});
            chk_val({28'h0, pin_oe_o}, {28'h0, w[2] ? 4'hf : gpio_oe_i});
            if (!w[2])
                chk_val({28'h0, pin_o}, {28'h0, gpio_out_i});
        end
        wr(16'hc017, 16'h0033);
        rd(sao_pkg::CFG_ADDR, {12'h0, w[3:0]});
        rd(16'hc017, 16'h0000);
        wr(sao_pkg::CFG_ADDR, 16'h000c);
        rd(sao_pkg::CFG_ADDR, 16'h000c);
        chk_val({28'h0, pin_oe_o}, 32'hf);
        for (int i = 0; i < 8; i++) begin
            hi_rng = i[2];
            wr(sao_pkg::CFG_ADDR, {12'h0, i[0] ^ i[2], 1'b1, i[1:0]});
            repeat (40) @(negedge ref_clk_i);
            measure(p, m);
            chk_val(32'(p), 32'(exp_period(i[1:0], i[2])));
            chk_val(32'(m), 32'(exp_mclk(i[0] ^ i[2], i[2])));
        end
        // slowest rate so the fifo cannot drain while it fills
        hi_rng = 1'b1;
        wr(sao_pkg::CFG_ADDR, 16'h000c);
        watch = 1'b1;
        smp_valid_i = 1'b1;
        for (int k = 0; k < 40; k++) begin
            smp_data_i = $urandom | 32'h1;
            if (!smp_ready_o)
                break;
            exp_q.push_back(smp_data_i);
            @(negedge ref_clk_i);
        end
        smp_valid_i = 1'b0;
        chk_val(32'(exp_q.size() >= 16 && exp_q.size() <= 17), 32'h1);
        for (int k = 0; k < 20000 && exp_q.size() > 0; k++)
            @(negedge ref_clk_i);
        if (exp_q.size() > 0)
            give_up();
        chk_val({31'h0, smp_ready_o}, 32'h1);
        end_of_test();
    end
endmodule
